// file: dv/fnau_props.sv
`include "fnau_cfg.svh"

// ================================================================
// bus-side properties of the float unit
module fnau_props (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr // apb error
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic unmapped;
    wire logic acc;
    assign unmapped = (paddr > `FNAU_ADDR_SC) || (paddr[1:0] != 2'h0);
    assign acc = psel && penable;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence rd_at(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence rd_xfer(a);
        rd_at(a) ##1 acc;
    endsequence

    ready_high_a: assert property (pready) else $error("ready low");
    err_unmapped_a: assert property (acc && unmapped |-> pslverr) else $error("no error on unmapped access");
    err_quiet_a: assert property (!(acc && unmapped) |-> !pslverr) else $error("stray error");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    unmapped_zero_a: assert property (psel && !penable && !pwrite && unmapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_field_a: assert property (rd_xfer(`FNAU_ADDR_CTRL) |-> prdata[31:4] == 28'h0)
        else $error("control start bit or spare bits set");
    stat_field_a: assert property (rd_xfer(`FNAU_ADDR_STAT) |-> prdata[31:6] == 26'h0)
        else $error("status spare bits set");
    chr_field_a: assert property (rd_at(`FNAU_ADDR_SR_CHR) or rd_at(`FNAU_ADDR_MQ_CHR) |=> prdata[31:9] == 23'h0)
        else $error("characteristic word too wide");
    ac_chr_field_a: assert property (rd_at(`FNAU_ADDR_AC_CHR) |=> prdata[31:11] == 21'h0)
        else $error("accumulator characteristic too wide");
    frac_field_a: assert property (rd_at(`FNAU_ADDR_AC_FRC) |=> prdata[31:27] == 5'h0)
        else $error("fraction word too wide");
    sc_field_a: assert property (rd_at(`FNAU_ADDR_SC) |=> prdata[31:8] == 24'h0)
        else $error("shift count too wide");
endmodule

// file: dv/fnau_seq_model.sv
// ================================================================
// sequencer side: apb master issuing register transfers
module fnau_seq_model (
    input wire logic clk_sys, // system clock
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    output logic psel, // apb select
    output logic penable, // apb enable
    output logic pwrite, // apb write
    output logic [7:0] paddr, // apb address
    output logic [31:0] pwdata // apb write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'h0;
    end

    // request held until ready seen; released bus shows inverted values
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// file: dv/tb.sv
`include "fnau_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] val; logic [31:0] mask;} fnau_note_s;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r1, r2, r3;
    logic [31:0] seed = 32'hE127;
    int n_mismatch = 0;
    int checks_done = 0;
    fnau_note_s notes[$];
    fnau_note_s cur;

    fnau_core u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fnau_seq_model u_seq (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // ================================================================
    // bus tasks; every read leaves a note for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{v, m});
        u_seq.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_seq.xfer(1'b1, a, d, q);
    endtask

    task automatic run(input logic [2:0] op, input logic nn, input logic [31:0] sc, sf, ac, af, mc, mf);
        wr(`FNAU_ADDR_SR_CHR, sc);
        wr(`FNAU_ADDR_SR_FRC, sf);
        wr(`FNAU_ADDR_AC_CHR, ac);
        wr(`FNAU_ADDR_AC_FRC, af);
        wr(`FNAU_ADDR_MQ_CHR, mc);
        wr(`FNAU_ADDR_MQ_FRC, mf);
        wr(`FNAU_ADDR_CTRL, {27'h0, 1'b1, nn, op});
        for (int i = 0; i < 300; i++) begin
            rd(`FNAU_ADDR_STAT, 32'h0, 32'h0);
            if (q[0] === 1'b0) break;
        end
    endtask

    // mode 1: characteristics cleared, mode 2: accumulator untouched
    task automatic md(input logic [2:0] op, input logic srz, input logic acz, input logic [5:0] st, input int mode);
        r1 = xorshift();
        r2 = xorshift();
        r3 = xorshift();
        run(op, 1'b0, {23'h0, r1[8:0]}, srz ? 32'h0 : {5'h0, r1[31:5] | 27'h1}, {21'h0, r3[10:0]},
            acz ? 32'h0 : {5'h0, r2[26:0] | 27'h1}, {23'h0, r3[31:23]}, acz ? 32'h0 : {5'h0, r3[26:0]});
        rd(`FNAU_ADDR_STAT, {26'h0, st}, 32'h3F);
        if (mode == 1) begin
            rd(`FNAU_ADDR_AC_CHR, 32'h0, 32'h3FF);
            rd(`FNAU_ADDR_MQ_CHR, 32'h0, 32'hFF);
        end else if (mode == 2) begin
            rd(`FNAU_ADDR_AC_CHR, {21'h0, r3[10:0]}, 32'h7FF);
            rd(`FNAU_ADDR_AC_FRC, {5'h0, r2[26:0] | 27'h1}, 32'h7FFFFFF);
        end
    endtask

    always @(posedge clk_sys) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            cur = notes.pop_front();
            if (cur.mask !== 32'h0) begin
                checks_done++;
                if ((prdata & cur.mask) !== (cur.val & cur.mask)) begin
                    n_mismatch++;
                    $display("CHECK FAILED reg %h expected %h seen %h", paddr, cur.val & cur.mask,
                        prdata & cur.mask);
                end
            end
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end

    // ================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`FNAU_ADDR_STAT, 32'h0, 32'hFFFFFFFF);
        for (int n = 0; n < 2; n++) begin
            run(`FNAU_OP_ADD, n[0], 32'h0, 32'h0, 32'h08B, 32'h0E00000, 32'h0, 32'h0);
            rd(`FNAU_ADDR_AC_CHR, n ? 32'h08B : 32'h088, 32'h7FF);
            rd(`FNAU_ADDR_AC_FRC, n ? 32'h0E00000 : 32'h7000000, 32'hFFFFFFFF);
            rd(`FNAU_ADDR_MQ_CHR, n ? 32'h070 : 32'h06D, 32'h1FF);
            rd(`FNAU_ADDR_SR_CHR, 32'h08B, 32'h1FF);
            rd(`FNAU_ADDR_STAT, 32'h02, 32'h3F);
            run(`FNAU_OP_ADD, n[0], 32'h085, 32'h0, 32'h080, 32'h0000021, 32'h0, 32'h0);
            rd(`FNAU_ADDR_AC_FRC, n ? 32'h0000001 : 32'h4200000, 32'hFFFFFFFF);
            rd(`FNAU_ADDR_MQ_FRC, n ? 32'h0400000 : 32'h0, 32'hFFFFFFFF);
            rd(`FNAU_ADDR_AC_CHR, n ? 32'h085 : 32'h06B, 32'h7FF);
            rd(`FNAU_ADDR_MQ_CHR, n ? 32'h06A : 32'h050, 32'h1FF);
            rd(`FNAU_ADDR_SC, 32'h0, 32'hFFFFFFFF);
        end
        run(`FNAU_OP_ADD, 1'b0, 32'h080, 32'h4000000, 32'h080, 32'h4000000, 32'h0, 32'h0);
        rd(`FNAU_ADDR_AC_CHR, 32'h081, 32'h7FF);
        rd(`FNAU_ADDR_AC_FRC, 32'h4000000, 32'hFFFFFFFF);
        run(`FNAU_OP_ADD, 1'b0, 32'h080, 32'h4000000, 32'h488, 32'h4000000, 32'h0, 32'h0);
        rd(`FNAU_ADDR_AC_CHR, 32'h487, 32'h7FF);
        rd(`FNAU_ADDR_AC_FRC, 32'h7F80000, 32'hFFFFFFFF);
        rd(`FNAU_ADDR_SR_CHR, 32'h188, 32'h1FF);
        rd(`FNAU_ADDR_MQ_CHR, 32'h16C, 32'h1FF);
        run(`FNAU_OP_SUB, 1'b0, 32'h080, 32'h4000000, 32'h080, 32'h4000000, 32'h0, 32'h0);
        rd(`FNAU_ADDR_STAT, 32'h10, 32'h11);
        rd(`FNAU_ADDR_AC_CHR, 32'h0, 32'h3FF);
        rd(`FNAU_ADDR_MQ_CHR, 32'h0, 32'hFF);
        run(`FNAU_OP_ADD, 1'b0, 32'h080, 32'h4000000, 32'h200, 32'h4000000, 32'h0, 32'h0);
        rd(`FNAU_ADDR_SR_CHR, 32'h0, 32'h1FF);
        rd(`FNAU_ADDR_AC_CHR, 32'h0, 32'h7FF);
        rd(`FNAU_ADDR_AC_FRC, 32'h4000000, 32'hFFFFFFFF);
        run(`FNAU_OP_ADD, 1'b0, 32'h0, 32'h1000000, 32'h0, 32'h0, 32'h0, 32'h0);
        rd(`FNAU_ADDR_STAT, 32'h04, 32'h05);
        md(`FNAU_OP_MPY, 1'b1, 1'b0, 6'h12, 1);
        md(`FNAU_OP_MPY, 1'b0, 1'b0, 6'h22, 0);
        md(`FNAU_OP_DMPY, 1'b0, 1'b1, 6'h12, 1);
        md(`FNAU_OP_DMPY, 1'b1, 1'b0, 6'h22, 0);
        md(`FNAU_OP_DIV, 1'b1, 1'b0, 6'h0A, 2);
        md(`FNAU_OP_DDIV, 1'b1, 1'b0, 6'h0A, 2);
        md(`FNAU_OP_DIV, 1'b0, 1'b1, 6'h12, 1);
        md(`FNAU_OP_DDIV, 1'b0, 1'b1, 6'h12, 1);
        wr(`FNAU_ADDR_STAT, 32'h0);
        rd(`FNAU_ADDR_STAT, 32'h12, 32'h3F);
        rd(`FNAU_ADDR_CTRL, 32'h5, 32'h1F);
        rd(8'h24, 32'h0, 32'hFFFFFFFF);
        give_verdict();
    end
endmodule

bind fnau_core fnau_props u_props (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: rtl/fnau_cfg.svh
`ifndef FNAU_CFG_SVH
`define FNAU_CFG_SVH

// ================================================================
// register byte addresses (apb, one 32-bit word each)
`define FNAU_ADDR_CTRL 8'h00
`define FNAU_ADDR_STAT 8'h04
`define FNAU_ADDR_SR_CHR 8'h08
`define FNAU_ADDR_SR_FRC 8'h0C
`define FNAU_ADDR_AC_CHR 8'h10
`define FNAU_ADDR_AC_FRC 8'h14
`define FNAU_ADDR_MQ_CHR 8'h18
`define FNAU_ADDR_MQ_FRC 8'h1C
`define FNAU_ADDR_SC 8'h20

// ================================================================
// control register fields
`define FNAU_CTRL_OP_LSB 0
`define FNAU_CTRL_NONORM 3
`define FNAU_CTRL_START 4
`define FNAU_CTRL_RESET 4'h0

// ================================================================
// operation codes
`define FNAU_OP_ADD 3'h0
`define FNAU_OP_SUB 3'h1
`define FNAU_OP_MPY 3'h2
`define FNAU_OP_DMPY 3'h3
`define FNAU_OP_DIV 3'h4
`define FNAU_OP_DDIV 3'h5

// ================================================================
// status register fields
`define FNAU_ST_BUSY 0
`define FNAU_ST_DONE 1
`define FNAU_ST_UNDER 2
`define FNAU_ST_DIVCHK 3
`define FNAU_ST_ZEROEND 4
`define FNAU_ST_HANDOFF 5

// ================================================================
// word layout and datapath figures
`define FNAU_CHR_SIGN_BIT 8
`define FNAU_AC_SIGN_BIT 10
`define FNAU_MQ_CHR_OFFSET 8'h1B
`define FNAU_ALIGN_LIMIT 10'h040

`endif

// file: rtl/fnau_core.sv
// Design decisions made here: register access over APB and the register offsets.
`include "fnau_cfg.svh"

// What this block does
// - result counts as normalized only when accumulator fraction bit 9 is one.
// - normalizing shifts left until bit 9 is one, characteristic minus one per shift.
// - normalize shifts act on accumulator plus extension fraction; top bits are lost.
// - normalize only when instruction sign is zero, after the result is formed.
// - normalize first, then extension characteristic is accumulator characteristic minus 27.
// - normalizing can drive the accumulator characteristic into underflow.
// - add and subtract still run with a zero-fraction operand, normalizing the other.
// - single multiply with zero multiplier ends early, clearing both characteristics.
// - double multiply tests the multiplicand instead, same early end and clearing.
// - divide by zero-fraction divisor raises divide check, dividend left alone.
// - divide with zero dividend ends, clearing both characteristics.
// - zero-fraction add or subtract result clears characteristic and ends.
// - operand holding and accumulator words hold sign, characteristic, fraction fields.
// - addition leaves result in accumulator; sign comes from the larger operand.
// - larger operand is swapped into the operand holding register before aligning.
// - q and p join the compare, are cleared on swap, and are left alone on entry.
// - shift counter gets characteristic difference; accumulator fraction shifts right that often.
// - align shift feeds zero into bit 9, bit 35 into extension bit 9.
// - difference of octal 100 or more clears accumulator q, p and fraction.
// - like signs add fractions; unlike signs add the complemented accumulator fraction.
// - true-add carry bumps characteristic, shifts fraction right, sets bit 9.
module fnau_core (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error, unmapped address
);

    // ================================================================
    // state
    fnau_pkg::fnau_state_e state_q;
    fnau_pkg::fnau_state_e state_d;
    fnau_pkg::fnau_word_s sr_q;
    fnau_pkg::fnau_word_s sr_d;
    fnau_pkg::fnau_acc_s ac_q;
    fnau_pkg::fnau_acc_s ac_d;
    fnau_pkg::fnau_word_s mq_q;
    fnau_pkg::fnau_word_s mq_d;
    logic [2:0] op_q;
    logic [2:0] op_d;
    logic nonorm_q;
    logic nonorm_d;
    logic [5:0] stat_q;
    logic [5:0] stat_d;
    logic [31:0] prdata_q;

    // ================================================================
    // apb decode
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_sr_chr;
    logic hit_sr_frc;
    logic hit_ac_chr;
    logic hit_ac_frc;
    logic hit_mq_chr;
    logic hit_mq_frc;
    logic hit_sc;
    logic mapped;
    logic idle;
    logic start;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign hit_ctrl = (paddr == `FNAU_ADDR_CTRL);
    assign hit_stat = (paddr == `FNAU_ADDR_STAT);
    assign hit_sr_chr = (paddr == `FNAU_ADDR_SR_CHR);
    assign hit_sr_frc = (paddr == `FNAU_ADDR_SR_FRC);
    assign hit_ac_chr = (paddr == `FNAU_ADDR_AC_CHR);
    assign hit_ac_frc = (paddr == `FNAU_ADDR_AC_FRC);
    assign hit_mq_chr = (paddr == `FNAU_ADDR_MQ_CHR);
    assign hit_mq_frc = (paddr == `FNAU_ADDR_MQ_FRC);
    assign hit_sc = (paddr == `FNAU_ADDR_SC);
    assign mapped = hit_ctrl | hit_stat | hit_sr_chr | hit_sr_frc | hit_ac_chr
                  | hit_ac_frc | hit_mq_chr | hit_mq_frc | hit_sc;
    assign idle = (state_q == fnau_pkg::ST_IDLE);
    assign start = wr_en && hit_ctrl && idle && pwdata[`FNAU_CTRL_START];

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // ================================================================
    // shift counter
    logic sc_load;
    logic sc_step;
    logic [7:0] sc_count;
    logic sc_zero;
    logic [9:0] chr_diff;
    logic diff_big;

    assign chr_diff = {2'b00, sr_q.chr} - ac_q.chr;
    assign diff_big = (chr_diff >= `FNAU_ALIGN_LIMIT);
    assign sc_load = (state_q == fnau_pkg::ST_DIFF) && !diff_big;
    assign sc_step = (state_q == fnau_pkg::ST_ALIGN);

    fnau_shift_count u_sc (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(sc_load),
        .load_val({2'b00, chr_diff[5:0]}),
        .step(sc_step),
        .count(sc_count),
        .zero(sc_zero)
    );

    always_comb begin
        case (1'b1)
            hit_ctrl: rd_mux = {27'h0, 1'b0, nonorm_q, op_q};
            hit_stat: rd_mux = {26'h0, stat_q};
            hit_sr_chr: rd_mux = {23'h0, sr_q.sign, sr_q.chr};
            hit_sr_frc: rd_mux = {5'h0, sr_q.frac};
            hit_ac_chr: rd_mux = {21'h0, ac_q.sign, ac_q.chr};
            hit_ac_frc: rd_mux = {5'h0, ac_q.frac};
            hit_mq_chr: rd_mux = {23'h0, mq_q.sign, mq_q.chr};
            hit_mq_frc: rd_mux = {5'h0, mq_q.frac};
            hit_sc: rd_mux = {24'h0, sc_count};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ================================================================
    // operand tests
    logic sr_fzero;
    logic ac_fzero;
    logic comb_zero;
    logic ac_bigger;
    logic like_signs;
    logic is_div;
    logic is_mpy;

    assign sr_fzero = (sr_q.frac == 27'h0);
    assign ac_fzero = (ac_q.frac == 27'h0);
    assign comb_zero = ac_fzero && (mq_q.frac == 27'h0);
    assign ac_bigger = (ac_q.chr > {2'b00, sr_q.chr});
    assign like_signs = (sr_q.sign == ac_q.sign);
    assign is_div = (op_q == `FNAU_OP_DIV) || (op_q == `FNAU_OP_DDIV);
    assign is_mpy = (op_q == `FNAU_OP_MPY) || (op_q == `FNAU_OP_DMPY);

    // ================================================================
    // fraction adder
    logic [27:0] tsum;
    logic [54:0] cdiff;
    logic [53:0] cmag;
    logic cneg;

    assign tsum = {1'b0, sr_q.frac} + {1'b0, ac_q.frac};
    assign cdiff = {1'b0, sr_q.frac, 27'h0} - {1'b0, ac_q.frac, mq_q.frac};
    assign cneg = cdiff[54];
    assign cmag = cneg ? (54'h0 - cdiff[53:0]) : cdiff[53:0];

    // ================================================================
    // sequencer and datapath
    always_comb begin
        state_d = state_q;
        sr_d = sr_q;
        ac_d = ac_q;
        mq_d = mq_q;
        op_d = op_q;
        nonorm_d = nonorm_q;
        stat_d = stat_q;
        case (state_q)
            fnau_pkg::ST_IDLE: begin
                if (wr_en) begin
                    if (hit_ctrl) begin
                        op_d = pwdata[`FNAU_CTRL_OP_LSB +: 3];
                        nonorm_d = pwdata[`FNAU_CTRL_NONORM];
                    end
                    if (hit_sr_chr) begin
                        sr_d.sign = pwdata[`FNAU_CHR_SIGN_BIT];
                        sr_d.chr = pwdata[7:0];
                    end
                    if (hit_sr_frc) begin
                        sr_d.frac = pwdata[26:0];
                    end
                    if (hit_ac_chr) begin
                        ac_d.sign = pwdata[`FNAU_AC_SIGN_BIT];
                        ac_d.chr = pwdata[9:0];
                    end
                    if (hit_ac_frc) begin
                        ac_d.frac = pwdata[26:0];
                    end
                    if (hit_mq_chr) begin
                        mq_d.sign = pwdata[`FNAU_CHR_SIGN_BIT];
                        mq_d.chr = pwdata[7:0];
                    end
                    if (hit_mq_frc) begin
                        mq_d.frac = pwdata[26:0];
                    end
                end
                if (start) begin
                    stat_d = 6'h01;
                    state_d = fnau_pkg::ST_ZCHK;
                    if (pwdata[`FNAU_CTRL_OP_LSB +: 3] == `FNAU_OP_SUB) begin
                        sr_d.sign = ~sr_q.sign;
                    end
                end
            end
            fnau_pkg::ST_ZCHK: begin
                state_d = fnau_pkg::ST_FIN;
                if (op_q == `FNAU_OP_ADD || op_q == `FNAU_OP_SUB) begin
                    mq_d = '0;
                    state_d = fnau_pkg::ST_CMP;
                end else if (is_div && sr_fzero) begin
                    stat_d[`FNAU_ST_DIVCHK] = 1'b1;
                    state_d = fnau_pkg::ST_IDLE;
                end else if ((op_q == `FNAU_OP_MPY && sr_fzero)
                          || (op_q == `FNAU_OP_DMPY && comb_zero)
                          || (is_div && comb_zero)) begin
                    ac_d.chr = 10'h000;
                    mq_d.chr = 8'h00;
                    stat_d[`FNAU_ST_ZEROEND] = 1'b1;
                    state_d = fnau_pkg::ST_IDLE;
                end else if (is_mpy || is_div) begin
                    stat_d[`FNAU_ST_HANDOFF] = 1'b1;
                    state_d = fnau_pkg::ST_IDLE;
                end else begin
                    state_d = fnau_pkg::ST_IDLE;
                end
                if (state_d == fnau_pkg::ST_IDLE) begin
                    stat_d[`FNAU_ST_BUSY] = 1'b0;
                    stat_d[`FNAU_ST_DONE] = 1'b1;
                end
            end
            fnau_pkg::ST_CMP: begin
                if (ac_bigger) begin
                    sr_d.sign = ac_q.sign;
                    sr_d.chr = ac_q.chr[7:0];
                    sr_d.frac = ac_q.frac;
                    ac_d.sign = sr_q.sign;
                    ac_d.chr = {2'b00, sr_q.chr};
                    ac_d.frac = sr_q.frac;
                end
                state_d = fnau_pkg::ST_DIFF;
            end
            fnau_pkg::ST_DIFF: begin
                if (diff_big) begin
                    ac_d.chr[9:8] = 2'b00;
                    ac_d.frac = 27'h0;
                    state_d = fnau_pkg::ST_ADD;
                end else begin
                    state_d = fnau_pkg::ST_ALIGN;
                end
            end
            fnau_pkg::ST_ALIGN: begin
                if (sc_zero) begin
                    state_d = fnau_pkg::ST_ADD;
                end else begin
                    mq_d.frac = {ac_q.frac[0], mq_q.frac[26:1]};
                    ac_d.frac = {1'b0, ac_q.frac[26:1]};
                end
            end
            fnau_pkg::ST_ADD: begin
                ac_d.sign = sr_q.sign;
                ac_d.chr = {2'b00, sr_q.chr};
                if (like_signs) begin
                    if (tsum[27]) begin
                        ac_d.chr = {2'b00, sr_q.chr} + 10'h001;
                        ac_d.frac = {1'b1, tsum[26:1]};
                        mq_d.frac = {tsum[0], mq_q.frac[26:1]};
                    end else begin
                        ac_d.frac = tsum[26:0];
                    end
                end else begin
                    ac_d.frac = cmag[53:27];
                    mq_d.frac = cmag[26:0];
                    if (cneg) begin
                        ac_d.sign = ac_q.sign;
                    end
                end
                state_d = fnau_pkg::ST_NORM;
            end
            fnau_pkg::ST_NORM: begin
                if (comb_zero) begin
                    ac_d.chr = 10'h000;
                    mq_d.chr = 8'h00;
                    mq_d.sign = ac_q.sign;
                    stat_d[`FNAU_ST_ZEROEND] = 1'b1;
                    stat_d[`FNAU_ST_BUSY] = 1'b0;
                    stat_d[`FNAU_ST_DONE] = 1'b1;
                    state_d = fnau_pkg::ST_IDLE;
                end else if (nonorm_q || ac_q.frac[26]) begin
                    state_d = fnau_pkg::ST_FIN;
                end else if (ac_q.chr == 10'h000) begin
                    stat_d[`FNAU_ST_UNDER] = 1'b1;
                    state_d = fnau_pkg::ST_FIN;
                end else begin
                    ac_d.frac = {ac_q.frac[25:0], mq_q.frac[26]};
                    mq_d.frac = {mq_q.frac[25:0], 1'b0};
                    ac_d.chr = ac_q.chr - 10'h001;
                end
            end
            fnau_pkg::ST_FIN: begin
                mq_d.chr = ac_q.chr[7:0] - `FNAU_MQ_CHR_OFFSET;
                mq_d.sign = ac_q.sign;
                stat_d[`FNAU_ST_BUSY] = 1'b0;
                stat_d[`FNAU_ST_DONE] = 1'b1;
                state_d = fnau_pkg::ST_IDLE;
            end
            default: begin
                state_d = fnau_pkg::ST_IDLE;
            end
        endcase
    end

    // ================================================================
    // registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= fnau_pkg::ST_IDLE;
            sr_q <= '0;
            ac_q <= '0;
            mq_q <= '0;
            op_q <= 3'h0;
            nonorm_q <= 1'b0;
            stat_q <= 6'h00;
        end else begin
            state_q <= state_d;
            sr_q <= sr_d;
            ac_q <= ac_d;
            mq_q <= mq_d;
            op_q <= op_d;
            nonorm_q <= nonorm_d;
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

endmodule

// file: rtl/fnau_pkg.sv
package fnau_pkg;

    // sign, characteristic bits 1-8, fraction bits 9-35
    typedef struct packed {
        logic sign;
        logic [7:0] chr;
        logic [26:0] frac;
    } fnau_word_s;

    // accumulator: chr[9:8] are the q and p overflow bits
    typedef struct packed {
        logic sign;
        logic [9:0] chr;
        logic [26:0] frac;
    } fnau_acc_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ZCHK,
        ST_CMP,
        ST_DIFF,
        ST_ALIGN,
        ST_ADD,
        ST_NORM,
        ST_FIN
    } fnau_state_e;

endpackage

// file: rtl/fnau_shift_count.sv
module fnau_shift_count (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic load, // load a new count
    input wire logic [7:0] load_val, // count to load
    input wire logic step, // count down by one
    output logic [7:0] count, // current count
    output logic zero // count is zero
);

    logic [7:0] count_q;
    logic [7:0] count_d;

    assign count_d = load ? load_val : (step && count_q != 8'h00) ? count_q - 8'h01 : count_q;
    assign count = count_q;
    assign zero = (count_q == 8'h00);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_d;
        end
    end

endmodule
